/* hw/dtc_map.svh */
// Purpose: timing figures for the dram command timing controller
// Assumes: 40 MHz controller clock; figures as printed, times in ps
// Notes: counts derive from times by rounding up to whole clocks
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

`define DTC_TCK_PS 25000
`define DTC_CK(ps) (((ps) + `DTC_TCK_PS - 1) / `DTC_TCK_PS)
`define DTC_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define DTC_RRD_MIN_CK 4
`define DTC_RRD_S_PS 5000
`define DTC_RRD_S_2K_PS 6000
`define DTC_RRD_L_PS 6000
`define DTC_RRD_L_2K_PS 7500
`define DTC_FAW_HALF_CK 16
`define DTC_FAW_1K_CK 20
`define DTC_FAW_2K_CK 28
`define DTC_FAW_HALF_PS 20000
`define DTC_FAW_1K_PS 25000
`define DTC_FAW_2K_PS 35000
`define DTC_WR_PS 15000
`define DTC_CRCDM_CK 4
`define DTC_CRCDM_PS 3750
`define DTC_PRE2_CK 1
`define DTC_WTR_L_CK 4
`define DTC_WTR_L_PS 7500
`define DTC_WTR_S_CK 2
`define DTC_WTR_S_PS 2500
`define DTC_CCD_S_CK 4
`define DTC_CCD_L_CK 4
`define DTC_CCD_L_PS 6250
`define DTC_MRD_CK 8
`define DTC_MRD_PDA_CK 16
`define DTC_MRD_PDA_PS 10000
`define DTC_MOD_CK 24
`define DTC_MOD_PS 15000
`define DTC_IWR_BL8_CK 4
`define DTC_IWR_BC4_CK 2
`define DTC_PL_CK 4
`define DTC_CRC_PW_MAX_CK 10
`define DTC_CPDED_CK 4
`define DTC_CT_EN_PS 200000
`define DTC_ZQINIT_CK 1024
`define DTC_ZQOPER_CK 512
`define DTC_DLLK_CK 597
`define DTC_RFC_PS 260000
`define DTC_XS_ADD_PS 10000
`define DTC_XS_CK `DTC_CK(`DTC_RFC_PS + `DTC_XS_ADD_PS)

`endif

/* hw/dtc_pkg.sv */
// Purpose: types shared by the dram command timing controller
// Assumes: nothing beyond the map header
// Notes: commands are abstract; pin encoding is left to the phy
package dtc_pkg;
	typedef enum logic [3:0] {DTC_DES, DTC_ACT, DTC_PRE, DTC_RD, DTC_WR, DTC_MRS, DTC_MPR_RD, DTC_MPR_WR,
		DTC_ZQCL, DTC_MPSM_IN, DTC_MPSM_OUT, DTC_CT_IN} dtc_cmd_t;
	typedef enum logic [1:0] {DTC_PG_HALF, DTC_PG_1K, DTC_PG_2K} dtc_page_t;
	typedef enum logic [1:0] {DTC_S_IDLE, DTC_S_CAL, DTC_S_CT} dtc_state_t;
	typedef enum int {DTC_C_ALL, DTC_C_MRD, DTC_C_MOD, DTC_C_DLL, DTC_C_ACT, DTC_C_COL, DTC_C_WTR, DTC_C_WR,
		DTC_C_NUM} dtc_cnt_t;
endpackage : dtc_pkg

/* hw/dtc_tmr_if.sv */
// Purpose: carries issue events and spacing loads to the timer modules
// Assumes: loads are already reduced by one clock
// Notes: act, col and rd ok flags refer to the candidate bank group; faw_ok covers all groups
`timescale 1ns/1ps
interface dtc_tmr_if #(parameter int BGW = 2, parameter int CW = 12);
	logic issue;
	dtc_pkg::dtc_cmd_t cmd;
	logic [BGW-1:0] bg;
	logic [BGW-1:0] cand_bg;
	logic [CW-1:0] rrd_l;
	logic [CW-1:0] ccd_l;
	logic [CW-1:0] wtr_l;
	logic [CW-1:0] faw;
	logic act_ok;
	logic col_ok;
	logic rd_ok;
	logic faw_ok;
	modport ctl (output issue, cmd, bg, cand_bg, rrd_l, ccd_l, wtr_l, faw, input act_ok, col_ok, rd_ok, faw_ok);
	modport bgt (input issue, cmd, bg, cand_bg, rrd_l, ccd_l, wtr_l, output act_ok, col_ok, rd_ok);
	modport fw (input issue, cmd, faw, output faw_ok);
endinterface : dtc_tmr_if

/* hw/dtc_bg_timer.sv */
// Purpose: per bank group spacing counters
// Assumes: one command issued per clock at most
// Notes: a reload never shortens a running wait
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_bg_timer #(parameter int BG_N = 4, parameter int CW = 12)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	dtc_tmr_if.bgt tif
);
	localparam int BGW = $clog2(BG_N);
	logic [BG_N-1:0] act_z;
	logic [BG_N-1:0] col_z;
	logic [BG_N-1:0] rd_z;

	genvar g;
	generate
		for (g = 0; g < BG_N; g++)
		begin : g_bg
			logic [CW-1:0] act_c;
			logic [CW-1:0] col_c;
			logic [CW-1:0] wtr_c;
			logic hit;
			logic [CW-1:0] act_d;
			logic [CW-1:0] col_d;
			logic [CW-1:0] wtr_d;
			assign hit = tif.issue && (tif.bg == BGW'(g));
			assign act_d = (act_c != '0) ? act_c - CW'(1) : act_c;
			assign col_d = (col_c != '0) ? col_c - CW'(1) : col_c;
			assign wtr_d = (wtr_c != '0) ? wtr_c - CW'(1) : wtr_c;
			always_ff @(posedge ref_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					act_c <= '0;
					col_c <= '0;
					wtr_c <= '0;
				end
				else
				begin
					act_c <= (hit && tif.cmd == dtc_pkg::DTC_ACT) ? `DTC_MAX(act_d, tif.rrd_l) : act_d;
					col_c <= (hit && (tif.cmd == dtc_pkg::DTC_RD || tif.cmd == dtc_pkg::DTC_WR)) ?
						`DTC_MAX(col_d, tif.ccd_l) : col_d;
					wtr_c <= (hit && tif.cmd == dtc_pkg::DTC_WR) ? `DTC_MAX(wtr_d, tif.wtr_l) : wtr_d;
				end
			end
			assign act_z[g] = (act_c == '0);
			assign col_z[g] = (col_c == '0);
			assign rd_z[g] = (wtr_c == '0);
		end
	endgenerate

	assign tif.act_ok = act_z[tif.cand_bg];
	assign tif.col_ok = col_z[tif.cand_bg];
	assign tif.rd_ok = rd_z[tif.cand_bg];
endmodule : dtc_bg_timer

/* hw/dtc_faw.sv */
// Purpose: four activate rolling window
// Assumes: load value is window length minus one
// Notes: four slots; an activate needs a free one
`timescale 1ns/1ps
module dtc_faw #(parameter int SLOTS = 4, parameter int CW = 12)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	dtc_tmr_if.fw tif
);
	logic [SLOTS-1:0] free;
	logic [SLOTS:0] prior;

	assign prior[0] = 1'b0;
	genvar s;
	generate
		for (s = 0; s < SLOTS; s++)
		begin : g_slot
			logic [CW-1:0] cnt;
			assign free[s] = (cnt == '0);
			assign prior[s+1] = prior[s] | free[s];
			always_ff @(posedge ref_clk or negedge reset_n)
			begin
				if (!reset_n)
					cnt <= '0;
				else if (tif.issue && tif.cmd == dtc_pkg::DTC_ACT && free[s] && !prior[s])
					cnt <= tif.faw;
				else if (cnt != '0)
					cnt <= cnt - CW'(1);
			end
		end
	endgenerate

	assign tif.faw_ok = prior[SLOTS];
endmodule : dtc_faw

/* hw/dtc_ctrl.sv */
// Purpose: spaces abstract dram commands to meet device timing
// Assumes: request held stable from req_valid until req_done
// Notes: all ns minimums rounded up at the 25 ns clock
// Function
// - activates across groups wait rrd short
// - activates in one group wait rrd long
// - at most four activates per window
// - write recovery before precharge, crc/dm extended
// - write to read same group wait
// - write to read other group wait
// - columns across groups four clocks apart
// - columns in one group wait ccd long
// - mode register commands spaced, pda longer
// - update delay before non mode commands
// - cal mode lengthens mrd and mod
// - mpr access gaps, mpr write longer
// - parity latency adds four clocks
// - persistent parity: only deselects after alert
// - chip select leads command by latency
// - power saving entry and exit waits
// - test enable before chip select
// - zq long calibration blocks all commands
// - ns minimums rounded up to clocks
// - internal write starts after write latency
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_ctrl #(
	parameter int BG_N = 4,
	parameter int CW = 12,
	parameter int TXS_CK = `DTC_XS_CK,
	parameter int BGW = $clog2(BG_N)
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire dtc_pkg::dtc_cmd_t req_cmd,
	input wire logic [BGW-1:0] req_bg,
	output logic req_done,
	input wire dtc_pkg::dtc_page_t cfg_page,
	input wire logic [4:0] cfg_cwl,
	input wire logic [4:0] cfg_al,
	input wire logic cfg_parity,
	input wire logic cfg_persist,
	input wire logic cfg_crc_dm,
	input wire logic cfg_pre2,
	input wire logic cfg_bc4_fixed,
	input wire logic cfg_pda,
	input wire logic cfg_cal_en,
	input wire logic [2:0] cfg_cal_lat,
	input wire logic alert_n,
	input wire logic err_clear,
	output logic crc_err,
	output logic parity_err,
	output logic alert_block,
	output logic in_mpsm,
	output logic cs_n,
	output dtc_pkg::dtc_cmd_t cmd_out,
	output logic [BGW-1:0] cmd_bg,
	output logic ten
);
	localparam int NC = dtc_pkg::DTC_C_NUM;

	dtc_tmr_if #(.BGW(BGW), .CW(CW)) tif ();

	dtc_pkg::dtc_state_t state;
	logic [CW-1:0] cnt [NC];
	logic [NC-1:0] ld_en;
	logic [CW-1:0] ld_val [NC];
	logic [NC-1:0] zero;
	logic zq_first;
	logic [7:0] wait_c;
	logic [7:0] alert_c;
	logic ok;
	logic issue;
	logic go_wait;
	logic finish;
	logic [CW-1:0] wl;
	logic [CW-1:0] iwr;
	logic [CW-1:0] cal;
	logic [CW-1:0] n_rrd_s;
	logic [CW-1:0] n_wr;
	logic [CW-1:0] n_wtr_l;
	logic [CW-1:0] n_wtr_s;
	logic [CW-1:0] n_mrd;
	logic [CW-1:0] n_mod;
	logic col_cmd;
	logic rd_cmd;

	genvar i;
	generate
		for (i = 0; i < NC; i++)
		begin : g_cnt
			logic [CW-1:0] dec;
			assign dec = (cnt[i] != '0) ? cnt[i] - CW'(1) : cnt[i];
			assign zero[i] = (cnt[i] == '0);
			always_ff @(posedge ref_clk or negedge reset_n)
			begin
				if (!reset_n)
					cnt[i] <= '0;
				else if (ld_en[i])
					cnt[i] <= `DTC_MAX(dec, ld_val[i]);
				else
					cnt[i] <= dec;
			end
		end
	endgenerate

	// ns figures rounded up to clocks
	always_comb
	begin
		cal = cfg_cal_en ? CW'(cfg_cal_lat) : '0;
		wl = CW'(cfg_cwl) + CW'(cfg_al) + (cfg_parity ? CW'(`DTC_PL_CK) : '0);
		iwr = wl + (cfg_bc4_fixed ? CW'(`DTC_IWR_BC4_CK) : CW'(`DTC_IWR_BL8_CK));
		n_rrd_s = (cfg_page == dtc_pkg::DTC_PG_2K) ? CW'(`DTC_MAX(`DTC_RRD_MIN_CK, `DTC_CK(`DTC_RRD_S_2K_PS))) :
			CW'(`DTC_MAX(`DTC_RRD_MIN_CK, `DTC_CK(`DTC_RRD_S_PS)));
		tif.rrd_l = (cfg_page == dtc_pkg::DTC_PG_2K) ?
			CW'(`DTC_MAX(`DTC_RRD_MIN_CK, `DTC_CK(`DTC_RRD_L_2K_PS)) - 1) :
			CW'(`DTC_MAX(`DTC_RRD_MIN_CK, `DTC_CK(`DTC_RRD_L_PS)) - 1);
		case (cfg_page)
			dtc_pkg::DTC_PG_HALF: tif.faw = CW'(`DTC_MAX(`DTC_FAW_HALF_CK, `DTC_CK(`DTC_FAW_HALF_PS)) - 1);
			dtc_pkg::DTC_PG_1K: tif.faw = CW'(`DTC_MAX(`DTC_FAW_1K_CK, `DTC_CK(`DTC_FAW_1K_PS)) - 1);
			default: tif.faw = CW'(`DTC_MAX(`DTC_FAW_2K_CK, `DTC_CK(`DTC_FAW_2K_PS)) - 1);
		endcase
		// recovery plus crc/dm and preamble adders
		n_wr = CW'(`DTC_CK(`DTC_WR_PS)) + (cfg_pre2 ? CW'(`DTC_PRE2_CK) : '0) +
			(cfg_crc_dm ? CW'(`DTC_MAX(`DTC_CRCDM_CK, `DTC_CK(`DTC_CRCDM_PS))) : '0);
		n_wtr_l = CW'(`DTC_MAX(`DTC_WTR_L_CK, `DTC_CK(`DTC_WTR_L_PS))) + (cfg_pre2 ? CW'(`DTC_PRE2_CK) : '0);
		n_wtr_s = CW'(`DTC_MAX(`DTC_WTR_S_CK, `DTC_CK(`DTC_WTR_S_PS))) + (cfg_pre2 ? CW'(`DTC_PRE2_CK) : '0);
		tif.wtr_l = iwr + n_wtr_l - CW'(1);
		tif.ccd_l = CW'(`DTC_MAX(`DTC_CCD_L_CK, `DTC_CK(`DTC_CCD_L_PS)) - 1);
		n_mrd = cfg_pda ? CW'(`DTC_MAX(`DTC_MRD_PDA_CK, `DTC_CK(`DTC_MRD_PDA_PS))) : CW'(`DTC_MRD_CK);
		n_mrd = n_mrd + cal;
		n_mod = CW'(`DTC_MAX(`DTC_MOD_CK, `DTC_CK(`DTC_MOD_PS))) + cal;
	end

	assign col_cmd = (req_cmd == dtc_pkg::DTC_RD) || (req_cmd == dtc_pkg::DTC_WR);
	assign rd_cmd = (req_cmd == dtc_pkg::DTC_RD) || (req_cmd == dtc_pkg::DTC_MPR_RD);
	assign tif.cand_bg = req_bg;
	assign tif.issue = issue;
	assign tif.cmd = req_cmd;
	assign tif.bg = req_bg;

	always_comb
	begin
		case (req_cmd)
			dtc_pkg::DTC_ACT: ok = zero[dtc_pkg::DTC_C_MOD] && zero[dtc_pkg::DTC_C_ACT] && tif.act_ok && tif.faw_ok;
			dtc_pkg::DTC_PRE: ok = zero[dtc_pkg::DTC_C_MOD] && zero[dtc_pkg::DTC_C_WR];
			// read waits on any write turnaround
			dtc_pkg::DTC_RD: ok = zero[dtc_pkg::DTC_C_MOD] && zero[dtc_pkg::DTC_C_COL] && tif.col_ok &&
				tif.rd_ok && zero[dtc_pkg::DTC_C_WTR] && zero[dtc_pkg::DTC_C_DLL];
			dtc_pkg::DTC_WR: ok = zero[dtc_pkg::DTC_C_MOD] && zero[dtc_pkg::DTC_C_COL] && tif.col_ok &&
				zero[dtc_pkg::DTC_C_DLL];
			dtc_pkg::DTC_MRS: ok = zero[dtc_pkg::DTC_C_MRD];
			dtc_pkg::DTC_MPR_RD: ok = zero[dtc_pkg::DTC_C_MOD] && zero[dtc_pkg::DTC_C_DLL];
			dtc_pkg::DTC_MPR_WR: ok = zero[dtc_pkg::DTC_C_MOD];
			dtc_pkg::DTC_ZQCL: ok = zero[dtc_pkg::DTC_C_MOD];
			dtc_pkg::DTC_MPSM_IN: ok = zero[dtc_pkg::DTC_C_MOD];
			dtc_pkg::DTC_MPSM_OUT: ok = in_mpsm;
			default: ok = 1'b1;
		endcase
	end

	assign issue = req_valid && ok && !req_done && state == dtc_pkg::DTC_S_IDLE && zero[dtc_pkg::DTC_C_ALL] &&
		!alert_block && (!in_mpsm || req_cmd == dtc_pkg::DTC_MPSM_OUT);
	assign go_wait = issue && (req_cmd == dtc_pkg::DTC_CT_IN || (cfg_cal_en && req_cmd != dtc_pkg::DTC_DES));
	assign finish = state != dtc_pkg::DTC_S_IDLE && wait_c == 8'h01;

	always_comb
	begin
		ld_en = '0;
		for (int k = 0; k < NC; k++)
			ld_val[k] = '0;
		if (issue)
		begin
			case (req_cmd)
				dtc_pkg::DTC_ACT:
				begin
					ld_en[dtc_pkg::DTC_C_ACT] = 1'b1;
					ld_val[dtc_pkg::DTC_C_ACT] = n_rrd_s - CW'(1);
				end
				dtc_pkg::DTC_RD, dtc_pkg::DTC_WR:
				begin
					ld_en[dtc_pkg::DTC_C_COL] = 1'b1;
					ld_val[dtc_pkg::DTC_C_COL] = CW'(`DTC_CCD_S_CK - 1);
					if (req_cmd == dtc_pkg::DTC_WR)
					begin
						ld_en[dtc_pkg::DTC_C_WTR] = 1'b1;
						ld_val[dtc_pkg::DTC_C_WTR] = iwr + n_wtr_s - CW'(1);
						ld_en[dtc_pkg::DTC_C_WR] = 1'b1;
						ld_val[dtc_pkg::DTC_C_WR] = iwr + n_wr - CW'(1);
					end
				end
				dtc_pkg::DTC_MRS:
				begin
					ld_en[dtc_pkg::DTC_C_MRD] = 1'b1;
					ld_val[dtc_pkg::DTC_C_MRD] = n_mrd - CW'(1);
					ld_en[dtc_pkg::DTC_C_MOD] = 1'b1;
					ld_val[dtc_pkg::DTC_C_MOD] = n_mod - CW'(1);
				end
				dtc_pkg::DTC_MPR_WR:
				begin
					// mpr write recovery; one clock for reads is inherent
					ld_en[dtc_pkg::DTC_C_MOD] = 1'b1;
					ld_val[dtc_pkg::DTC_C_MOD] = n_mod + CW'(cfg_al) + (cfg_parity ? CW'(`DTC_PL_CK) : '0) - CW'(1);
				end
				dtc_pkg::DTC_ZQCL:
				begin
					ld_en[dtc_pkg::DTC_C_ALL] = 1'b1;
					ld_val[dtc_pkg::DTC_C_ALL] = zq_first ? CW'(`DTC_ZQINIT_CK - 1) : CW'(`DTC_ZQOPER_CK - 1);
				end
				dtc_pkg::DTC_MPSM_IN:
				begin
					ld_en[dtc_pkg::DTC_C_ALL] = 1'b1;
					ld_val[dtc_pkg::DTC_C_ALL] = n_mod + CW'(`DTC_CPDED_CK - 1);
				end
				dtc_pkg::DTC_MPSM_OUT:
				begin
					ld_en[dtc_pkg::DTC_C_ALL] = 1'b1;
					ld_val[dtc_pkg::DTC_C_ALL] = CW'(TXS_CK - 1);
					ld_en[dtc_pkg::DTC_C_DLL] = 1'b1;
					ld_val[dtc_pkg::DTC_C_DLL] = CW'(TXS_CK + `DTC_DLLK_CK - 1);
				end
				default:
				begin
					ld_en = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			zq_first <= 1'b1;
			in_mpsm <= 1'b0;
		end
		else if (issue)
		begin
			if (req_cmd == dtc_pkg::DTC_ZQCL)
				zq_first <= 1'b0;
			if (req_cmd == dtc_pkg::DTC_MPSM_IN)
				in_mpsm <= 1'b1;
			else if (req_cmd == dtc_pkg::DTC_MPSM_OUT)
				in_mpsm <= 1'b0;
		end
	end

	// pin sequencer: cal lead or test enable wait
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= dtc_pkg::DTC_S_IDLE;
			wait_c <= '0;
			cs_n <= 1'b1;
			cmd_out <= dtc_pkg::DTC_DES;
			cmd_bg <= '0;
			ten <= 1'b0;
			req_done <= 1'b0;
		end
		else
		begin
			cs_n <= 1'b1;
			cmd_out <= dtc_pkg::DTC_DES;
			req_done <= (issue && !go_wait) || finish;
			case (state)
				dtc_pkg::DTC_S_IDLE:
				begin
					if (go_wait && req_cmd == dtc_pkg::DTC_CT_IN)
					begin
						ten <= 1'b1;
						wait_c <= 8'(`DTC_CK(`DTC_CT_EN_PS));
						state <= dtc_pkg::DTC_S_CT;
					end
					else if (go_wait)
					begin
						cs_n <= 1'b0;
						cmd_bg <= req_bg;
						wait_c <= 8'(cfg_cal_lat);
						state <= dtc_pkg::DTC_S_CAL;
					end
					else if (issue)
					begin
						cs_n <= (req_cmd == dtc_pkg::DTC_DES);
						cmd_out <= req_cmd;
						cmd_bg <= req_bg;
					end
				end
				dtc_pkg::DTC_S_CAL:
				begin
					wait_c <= wait_c - 8'h01;
					if (finish || wait_c == 8'h00)
					begin
						cmd_out <= req_cmd;
						state <= dtc_pkg::DTC_S_IDLE;
					end
				end
				dtc_pkg::DTC_S_CT:
				begin
					wait_c <= wait_c - 8'h01;
					if (finish)
					begin
						cs_n <= 1'b0;
						state <= dtc_pkg::DTC_S_IDLE;
					end
				end
				default:
				begin
					state <= dtc_pkg::DTC_S_IDLE;
				end
			endcase
		end
	end

	// short alert pulse means crc error
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			alert_c <= '0;
			crc_err <= 1'b0;
			parity_err <= 1'b0;
			alert_block <= 1'b0;
		end
		else
		begin
			if (!alert_n)
				alert_c <= (alert_c == 8'hff) ? alert_c : alert_c + 8'h01;
			else
				alert_c <= '0;
			// set wins over clear
			crc_err <= (alert_n && alert_c != '0 && alert_c <= 8'(`DTC_CRC_PW_MAX_CK)) || (crc_err && !err_clear);
			// long pulse is a parity alert
			parity_err <= (alert_n && alert_c > 8'(`DTC_CRC_PW_MAX_CK)) || (parity_err && !err_clear);
			alert_block <= cfg_persist && !alert_n;
		end
	end

	dtc_bg_timer #(.BG_N(BG_N), .CW(CW)) u_bg (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tif(tif.bgt)
	);

	dtc_faw #(.SLOTS(4), .CW(CW)) u_faw (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tif(tif.fw)
	);
endmodule : dtc_ctrl

/* testbench/dtc_ctrl_chk.sv */
// Purpose: pin timing checks on the command controller
// Assumes: cal latency of 3 whenever cal mode is on
// Notes: faw checked at its shortest window only
`timescale 1ns/1ps
module dtc_ctrl_chk
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire dtc_pkg::dtc_cmd_t cmd_out,
	input wire logic cs_n,
	input wire logic ten,
	input wire logic alert_n,
	input wire logic crc_err,
	input wire logic parity_err,
	input wire logic alert_block,
	input wire logic cfg_persist,
	input wire logic cfg_cal_en,
	input wire logic [2:0] cfg_cal_lat
);
	logic [14:0] act_h;
	logic [7:0] low_len;
	logic [10:0] mrs_age;
	logic [10:0] zq_age;
	logic is_cmd;
	logic is_col;
	assign is_cmd = cmd_out != dtc_pkg::DTC_DES;
	assign is_col = cmd_out inside {dtc_pkg::DTC_RD, dtc_pkg::DTC_WR};
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	// ages saturate so a long quiet spell never wraps into a false hit
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			act_h <= '0;
			low_len <= '0;
			mrs_age <= '1;
			zq_age <= '1;
		end
		else
		begin
			act_h <= {act_h[13:0], cmd_out == dtc_pkg::DTC_ACT};
			low_len <= alert_n ? 8'h00 : low_len + {7'h00, low_len != 8'hff};
			mrs_age <= (cmd_out == dtc_pkg::DTC_MRS) ? 11'h001 : mrs_age + {10'h000, mrs_age != 11'h7ff};
			zq_age <= (cmd_out == dtc_pkg::DTC_ZQCL) ? 11'h001 : zq_age + {10'h000, zq_age != 11'h7ff};
		end
	end
	property p_act; cmd_out == dtc_pkg::DTC_ACT |=> (cmd_out != dtc_pkg::DTC_ACT) [*3]; endproperty
	a_act: assert property (p_act) else $error("act gap short");
	property p_col; is_col |=> !is_col [*3]; endproperty
	a_col: assert property (p_col) else $error("column gap short");
	property p_mrd; cmd_out == dtc_pkg::DTC_MRS |=> (cmd_out != dtc_pkg::DTC_MRS) [*7]; endproperty
	a_mrd: assert property (p_mrd) else $error("mode gap short");
	property p_mod; is_cmd && cmd_out inside {dtc_pkg::DTC_ACT, dtc_pkg::DTC_RD, dtc_pkg::DTC_WR} |-> mrs_age >= 11'h018; endproperty
	a_mod: assert property (p_mod) else $error("update delay short");
	property p_faw; cmd_out == dtc_pkg::DTC_ACT |-> $countones(act_h) <= 3; endproperty
	a_faw: assert property (p_faw) else $error("five acts in window");
	property p_zq; is_cmd |-> zq_age >= 11'h200; endproperty
	a_zq: assert property (p_zq) else $error("command during zq");
	property p_ten; $rose(ten) |-> cs_n [*8]; endproperty
	a_ten: assert property (p_ten) else $error("chip select too early");
	property p_cal; !cs_n && cfg_cal_en && cfg_cal_lat == 3'h3 |-> !is_cmd ##3 (is_cmd && cs_n); endproperty
	a_cal: assert property (p_cal) else $error("cal latency wrong");
	property p_crc; $rose(alert_n) && low_len inside {[8'h01:8'h0a]} |-> ##[1:2] crc_err; endproperty
	a_crc: assert property (p_crc) else $error("short alert not crc");
	property p_par; $rose(alert_n) && low_len > 8'h0a |-> ##[1:2] parity_err; endproperty
	a_par: assert property (p_par) else $error("long alert not parity");
	property p_blk; alert_block && !cfg_cal_en |=> !is_cmd; endproperty
	a_blk: assert property (p_blk) else $error("issue while blocked");
	property p_blkon; cfg_persist && !alert_n |=> alert_block; endproperty
	a_blkon: assert property (p_blkon) else $error("alert did not block");
endmodule : dtc_ctrl_chk
bind dtc_ctrl dtc_ctrl_chk u_chk (.ref_clk, .reset_n, .cmd_out, .cs_n, .ten, .alert_n, .crc_err,
	.parity_err, .alert_block, .cfg_persist, .cfg_cal_en, .cfg_cal_lat);

/* testbench/dtc_dev_model.sv */
// Purpose: device side, answers commands with alert pulses
// Assumes: inject held until the errant command is seen
// Notes: only the alert pin is modelled, no data path
`timescale 1ns/1ps
module dtc_dev_model
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire dtc_pkg::dtc_cmd_t cmd_out,
	input wire logic [1:0] inject,
	output logic alert_n
);
	int w;
	initial alert_n = 1'b1;
	always @(posedge ref_clk)
	begin
		if (reset_n && cmd_out != dtc_pkg::DTC_DES && inject != 2'h0)
		begin
			w = (inject == 2'h1) ? 8 : 60;
			if (inject == 2'h2)
				repeat (4) @(posedge ref_clk);
			#5 alert_n = 1'b0;
			repeat (w) @(posedge ref_clk);
			#5 alert_n = 1'b1;
		end
	end
endmodule : dtc_dev_model

/* testbench/tb.sv */
// Purpose: spacing and alert tests of the command controller
// Assumes: one request at a time, held until done
// Notes: gaps measured between commands seen on the pins
`timescale 1ns/1ps
module tb;
	localparam int TXS = 6;
	logic ref_clk = 1'b0;
	logic reset_n, req_valid, req_done, crc_err, parity_err, alert_block, in_mpsm, cs_n, ten, alert_n;
	logic cfg_parity, cfg_persist, cfg_crc_dm, cfg_pre2, cfg_bc4_fixed, cfg_pda, cfg_cal_en, err_clear;
	logic [4:0] cfg_cwl, cfg_al;
	logic [2:0] cfg_cal_lat;
	logic [1:0] req_bg, cmd_bg, inject;
	dtc_pkg::dtc_cmd_t req_cmd, cmd_out;
	dtc_pkg::dtc_page_t cfg_page;
	logic [16:0] rnd = 17'h137a1;
	int n_errors = 0, cmp_count = 0, cyc = 0, zq_n = 0;
	int tq[$];
	dtc_ctrl #(.TXS_CK(TXS)) dut (.ref_clk, .reset_n, .req_valid, .req_cmd, .req_bg, .req_done, .cfg_page,
		.cfg_cwl, .cfg_al, .cfg_parity, .cfg_persist, .cfg_crc_dm, .cfg_pre2, .cfg_bc4_fixed, .cfg_pda,
		.cfg_cal_en, .cfg_cal_lat, .alert_n, .err_clear, .crc_err, .parity_err, .alert_block, .in_mpsm,
		.cs_n, .cmd_out, .cmd_bg, .ten);
	dtc_dev_model u_dev (.ref_clk, .reset_n, .cmd_out, .inject, .alert_n);
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (reset_n === 1'b1 && cmd_out !== dtc_pkg::DTC_DES)
			tq.push_back(cyc);
		if (cyc == 20000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	function automatic logic [16:0] lfsr(input logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction : lfsr
	function automatic int gap(input dtc_pkg::dtc_cmd_t a, input logic [1:0] ba, input dtc_pkg::dtc_cmd_t b,
		input logic [1:0] bb);
		int wl;
		int cal;
		int g;
		wl = cfg_cwl + cfg_al + 4 * cfg_parity;
		cal = cfg_cal_en ? cfg_cal_lat : 0;
		g = 2;
		if (a == b && b inside {dtc_pkg::DTC_ACT, dtc_pkg::DTC_RD, dtc_pkg::DTC_WR})
			g = 4;
		if (a == dtc_pkg::DTC_WR && b == dtc_pkg::DTC_RD)
			g = wl + (cfg_bc4_fixed ? 2 : 4) + (ba == bb ? 4 : 2) + cfg_pre2;
		if (a == dtc_pkg::DTC_WR && b == dtc_pkg::DTC_PRE)
			g = wl + (cfg_bc4_fixed ? 2 : 4) + 1 + (cfg_crc_dm ? 4 : 0) + cfg_pre2;
		if (a == dtc_pkg::DTC_MRS)
			g = (b == dtc_pkg::DTC_MRS ? (cfg_pda ? 16 : 8) : 24) + cal;
		if (a == dtc_pkg::DTC_MPSM_IN)
			g = 28;
		if (a == dtc_pkg::DTC_MPSM_OUT)
			g = (b == dtc_pkg::DTC_RD) ? TXS + 597 : TXS;
		if (a == dtc_pkg::DTC_ZQCL)
			g = zq_n == 0 ? 1024 : 512;
		if (a == dtc_pkg::DTC_MPR_WR)
			g = 24 + cal + cfg_al + 4 * cfg_parity;
		return g;
	endfunction : gap
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// request stays up on return so a follow-up can come in the done cycle
	task automatic issue(input dtc_pkg::dtc_cmd_t c, input logic [1:0] b);
		int k;
		req_valid = 1'b1;
		req_cmd = c;
		req_bg = b;
		k = 0;
		do
		begin
			@(negedge ref_clk);
			k++;
		end
		while (req_done !== 1'b1 && k < 2000);
		chk(k < 2000, 1'b1);
	endtask : issue
	task automatic idle(input int n);
		req_valid = 1'b0;
		repeat (n) @(negedge ref_clk);
	endtask : idle
	task automatic pair(input dtc_pkg::dtc_cmd_t a, input logic [1:0] ba, input dtc_pkg::dtc_cmd_t b,
		input logic [1:0] bb);
		issue(a, ba);
		issue(b, bb);
		idle(2);
		chk(tq[$] - tq[$-1], gap(a, ba, b, bb));
		idle(40);
	endtask : pair
	initial
	begin
		{reset_n, req_valid, req_bg, inject, err_clear, cfg_al, cfg_parity, cfg_persist} = '0;
		{cfg_crc_dm, cfg_pre2, cfg_bc4_fixed, cfg_pda, cfg_cal_en} = '0;
		req_cmd = dtc_pkg::DTC_DES;
		cfg_page = dtc_pkg::DTC_PG_HALF;
		cfg_cwl = 5'h09;
		cfg_cal_lat = 3'h3;
		repeat (5) @(negedge ref_clk);
		reset_n = 1'b1;
		pair(dtc_pkg::DTC_ZQCL, 2'h0, dtc_pkg::DTC_ACT, 2'h0);
		zq_n = 1;
		pair(dtc_pkg::DTC_ZQCL, 2'h0, dtc_pkg::DTC_ACT, 2'h1);
		pair(dtc_pkg::DTC_ACT, 2'h0, dtc_pkg::DTC_ACT, 2'h1);
		pair(dtc_pkg::DTC_ACT, 2'h3, dtc_pkg::DTC_ACT, 2'h3);
		pair(dtc_pkg::DTC_RD, 2'h0, dtc_pkg::DTC_RD, 2'h1);
		pair(dtc_pkg::DTC_WR, 2'h2, dtc_pkg::DTC_WR, 2'h2);
		$display("end act and column");
		for (int p = 0; p < 3; p++)
		begin
			cfg_page = dtc_pkg::dtc_page_t'(p);
			for (int i = 0; i < 5; i++)
				issue(dtc_pkg::DTC_ACT, i[1:0]);
			idle(2);
			chk(tq[$] - tq[$-4], p == 0 ? 16 : (p == 1 ? 20 : 28));
			idle(40);
		end
		$display("end window");
		for (int i = 0; i < 8; i++)
		begin
			rnd = lfsr(rnd);
			cfg_cwl = 5'h09 + {2'h0, rnd[2:0]};
			cfg_al = {3'h0, rnd[4:3]};
			{cfg_parity, cfg_pre2, cfg_bc4_fixed, cfg_crc_dm} = rnd[8:5];
			pair(dtc_pkg::DTC_WR, rnd[10:9], dtc_pkg::DTC_RD, rnd[12:11]);
			pair(dtc_pkg::DTC_WR, rnd[14:13], dtc_pkg::DTC_PRE, rnd[16:15]);
		end
		$display("end write turnaround");
		pair(dtc_pkg::DTC_MRS, 2'h0, dtc_pkg::DTC_MRS, 2'h0);
		cfg_pda = 1'b1;
		pair(dtc_pkg::DTC_MRS, 2'h0, dtc_pkg::DTC_MRS, 2'h0);
		cfg_pda = 1'b0;
		cfg_cal_en = 1'b1;
		pair(dtc_pkg::DTC_MRS, 2'h0, dtc_pkg::DTC_MRS, 2'h0);
		pair(dtc_pkg::DTC_MRS, 2'h0, dtc_pkg::DTC_ACT, 2'h1);
		cfg_cal_en = 1'b0;
		pair(dtc_pkg::DTC_MRS, 2'h0, dtc_pkg::DTC_ACT, 2'h1);
		pair(dtc_pkg::DTC_MPR_WR, 2'h0, dtc_pkg::DTC_MPR_RD, 2'h0);
		$display("end mode register");
		pair(dtc_pkg::DTC_MPSM_IN, 2'h0, dtc_pkg::DTC_MPSM_OUT, 2'h0);
		issue(dtc_pkg::DTC_MPSM_IN, 2'h0);
		idle(40);
		pair(dtc_pkg::DTC_MPSM_OUT, 2'h0, dtc_pkg::DTC_ACT, 2'h1);
		issue(dtc_pkg::DTC_MPSM_IN, 2'h0);
		idle(40);
		chk(in_mpsm, 1'b1);
		pair(dtc_pkg::DTC_MPSM_OUT, 2'h0, dtc_pkg::DTC_RD, 2'h2);
		chk(cmd_bg, 2'h2);
		$display("end power saving");
		inject = 2'h1;
		issue(dtc_pkg::DTC_WR, 2'h0);
		idle(20);
		chk({crc_err, parity_err}, 2'h2);
		err_clear = 1'b1;
		idle(2);
		err_clear = 1'b0;
		chk(crc_err, 1'b0);
		cfg_persist = 1'b1;
		inject = 2'h2;
		issue(dtc_pkg::DTC_ACT, 2'h1);
		idle(8);
		inject = 2'h0;
		chk(alert_block, 1'b1);
		// blocked request must wait out the whole alert pulse
		issue(dtc_pkg::DTC_PRE, 2'h1);
		idle(2);
		chk(tq[$] - tq[$-1] > 48, 1'b1);
		chk({crc_err, parity_err, alert_block}, 3'h2);
		cfg_persist = 1'b0;
		$display("end alert");
		issue(dtc_pkg::DTC_CT_IN, 2'h0);
		idle(2);
		chk(ten, 1'b1);
		reset_n = 1'b0;
		idle(2);
		reset_n = 1'b1;
		chk({ten, cs_n}, 2'h1);
		$display("end test mode");
		end_of_test();
	end
endmodule : tb
